// ==== sbo_output_ctrl.sv ====
// Purpose: Eight-channel frame builder with output enable and self-test control
// Assumes: Transmit clock is far slower than clk_i and is sampled here
// Notes:   Frames leave as 12-bit words; a hard serializer shifts them out
`timescale 1ns/1ps
`default_nettype none
`include "sbo_consts.svh"

module sbo_output_ctrl #(
    parameter int unsigned RUNBIST_FRAMES = `SBO_RUNBIST_TIME_US * `SBO_SYS_CLK_MHZ
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             transmit_ref_clock_i,
    input  wire logic             driver_output_enable_i,
    input  wire logic             master_sleep_n_i,
    input  wire logic [7:0]       channel_sleep_n_i,
    input  wire logic [7:0]       sync_request_i,
    input  wire logic             selftest_activate_i,
    input  wire logic [3:0]       selftest_channel_select_i,
    input  wire logic [7:0][9:0]  parallel_word_in_i,
    output logic      [7:0][11:0] serial_out_pairs_o,
    output logic      [7:0]       serial_drive_n_o,
    output logic                  frame_strobe_o
);
    // Select pins reset high like weak pull-ups, so nothing tests by default
    localparam logic [103:0] PIN_RST = {80'h0, `SBO_SEL_PULLUP, 20'h0};
    localparam logic [21:0]  RB_LAST = 22'(RUNBIST_FRAMES - 1);

    sbo_pkg::sbo_state_s q;
    sbo_pkg::sbo_state_s n;

    logic [103:0]     pin_raw;
    logic [103:0]     pin_s;
    logic             s_transmit_ref_clock;
    logic             s_den;
    logic             s_master;
    logic [7:0]       s_sync;
    logic [7:0]       s_sleep;
    logic             s_act;
    logic [3:0]       s_sel;
    logic [7:0][9:0]  s_word;
    logic             tick;
    logic             rb_run;
    logic             ext_on;
    logic [7:0]       pin_pick;
    logic [7:0]       in_prbs;
    logic [9:0]       prbs_word;

    // -----------------------------------------------------------------
    // Pin synchronizers
    // -----------------------------------------------------------------
    assign pin_raw = {parallel_word_in_i, selftest_channel_select_i, selftest_activate_i,
                      channel_sleep_n_i, sync_request_i, master_sleep_n_i,
                      driver_output_enable_i, transmit_ref_clock_i};

    sbo_pin_sync #(
        .W       (104),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pin_raw),
        .q_o   (pin_s)
    );

    // Field split of the synchronized pins
    assign s_transmit_ref_clock   = pin_s[0];
    assign s_den    = pin_s[1];
    assign s_master = pin_s[2];
    assign s_sync   = pin_s[10:3];
    assign s_sleep  = pin_s[18:11];
    assign s_act    = pin_s[19];
    assign s_sel    = pin_s[23:20];
    assign s_word   = pin_s[103:24];

    // -----------------------------------------------------------------
    // Frame tick and pattern source
    // -----------------------------------------------------------------
    // Rising transmit clock edge; words are captured here for all channels
    assign tick = s_transmit_ref_clock & ~q.transmit_ref_clock_prev;

    sbo_prbs_gen u_prbs (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .adv_i  (tick),
        .word_o (prbs_word)
    );

    // Pin test decode: 0..7 one channel, 8 all, 9..F none, inactive none
    function automatic logic [7:0] sel_mask(input logic act, input logic [3:0] sel);
        logic [7:0] m;
        m = 8'h00;
        if (act && sel == `SBO_SEL_ALL) begin
            m = 8'hff;
        end else if (act && !sel[3]) begin
            m[sel[2:0]] = 1'b1;
        end
        return m;
    endfunction

    // Test pins act only through the copy taken on a frame tick
    assign pin_pick = sel_mask(q.selftest_activate, q.bist_sel);
    assign rb_run   = (q.instr == `SBO_INSTR_RUNBIST) && q.rti && !q.bist_done;
    assign ext_on   = (q.instr == `SBO_INSTR_EXTEST);

    always_comb begin
        for (int ch = 0; ch < 8; ch++) begin
            in_prbs[ch] = (q.mode[ch] == sbo_pkg::SBO_MODE_PRBS);
        end
    end

    // Register read mux; unmapped words read as zero
    function automatic logic [31:0] reg_read(input logic [7:0] adr,
                                             input sbo_pkg::sbo_state_s s);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (adr)
            `SBO_ADR_CTRL:   r = {29'h0, s.rti, s.instr};
            `SBO_ADR_EXTEST: r = {24'h0, s.extest};
            `SBO_ADR_STATUS: r = {3'h0, s.selftest_activate, s.bist_sel, s.sync_mode, ~s.drive_n,
                                  5'h0, |in_prbs, rb_run, s.bist_done};
            `SBO_ADR_FRAMES: r = {10'h0, s.bist_frames};
            default:         r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        n           = q;
        n.frame_stb = 1'b0;
        n.transmit_ref_clock_prev = s_transmit_ref_clock;

        // Enables follow the pins every cycle, not only per frame, so that a
        // tri-state request bites at once; frames keep running underneath,
        // which is what lets the link pick up where it left off
        for (int ch = 0; ch < 8; ch++) begin
            n.drive_n[ch] = ~(s_den & s_master & s_sleep[ch]);
        end

        if (tick) begin
            n.frame_stb = 1'b1;
            n.selftest_activate  = s_act;
            n.bist_sel  = s_sel;
            if (rb_run) begin
                n.bist_frames = 22'(q.bist_frames + 22'h1);
                if (q.bist_frames == RB_LAST) begin
                    n.bist_done = 1'b1;
                end
            end
            for (int ch = 0; ch < 8; ch++) begin
                // Count frames with sync high, saturating at the hold count
                if (!s_sync[ch]) begin
                    n.sync_cnt[ch] = 3'h0;
                end else if (q.sync_cnt[ch] != `SBO_SYNC_HOLD) begin
                    n.sync_cnt[ch] = 3'(q.sync_cnt[ch] + 3'h1);
                end
                n.sync_mode[ch] = (n.sync_cnt[ch] == `SBO_SYNC_HOLD);

                // Source priority: sleep, scan test, pattern, sync, data
                if (!(s_master && s_sleep[ch])) begin
                    n.mode[ch]  = sbo_pkg::SBO_MODE_SLEEP;
                    n.frame[ch] = 12'h000;
                end else if (ext_on) begin
                    n.mode[ch]  = sbo_pkg::SBO_MODE_TEST_LVL;
                    n.frame[ch] = {12{q.extest[ch]}};
                end else if (rb_run || pin_pick[ch]) begin
                    n.mode[ch]  = sbo_pkg::SBO_MODE_PRBS;
                    n.frame[ch] = {`SBO_STOP_BIT, prbs_word, `SBO_START_BIT};
                end else if (n.sync_mode[ch]) begin
                    n.mode[ch]  = sbo_pkg::SBO_MODE_SYNC;
                    n.frame[ch] = `SBO_SYNC_FRAME;
                end else begin
                    n.mode[ch]  = sbo_pkg::SBO_MODE_DATA;
                    n.frame[ch] = {`SBO_STOP_BIT, s_word[ch], `SBO_START_BIT};
                end
            end
        end

        // Leaving the test instruction rearms it for the next run
        if (q.instr != `SBO_INSTR_RUNBIST) begin
            n.bist_frames = 22'h0;
            n.bist_done   = 1'b0;
        end

        // Classic Wishbone: ack one cycle after the strobe, for one cycle
        n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        if (n.ack) begin
            n.rdat = reg_read(wb_adr_i, q);
        end
        if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0]) begin
            if (wb_adr_i == `SBO_ADR_CTRL) begin
                n.instr = wb_dat_i[1:0];
                n.rti   = wb_dat_i[`SBO_CTRL_RTI_BIT];
            end else if (wb_adr_i == `SBO_ADR_EXTEST) begin
                n.extest = wb_dat_i[7:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q          <= '0;
            q.bist_sel <= `SBO_SEL_PULLUP;
            q.drive_n  <= 8'hff;
        end else begin
            q <= n;
        end
    end

    // Every output is a state flop
    assign wb_dat_o           = q.rdat;
    assign wb_ack_o           = q.ack;
    assign serial_out_pairs_o = q.frame;
    assign serial_drive_n_o   = q.drive_n;
    assign frame_strobe_o     = q.frame_stb;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_den_tristate:
    assert property (!s_den |=> serial_drive_n_o == 8'hff)
        else $error("outputs driven while driver enable low");

    chk_den_resume:
    assert property ($rose(s_den) && s_master && s_sleep[0] |=> !serial_drive_n_o[0])
        else $error("channel 0 did not resume driving");

    chk_sel_one:
    assert property (q.selftest_activate && q.bist_sel < 4'h8 |-> pin_pick == (8'h01 << q.bist_sel[2:0]))
        else $error("single channel select decode wrong");

    chk_sel_all:
    assert property (q.selftest_activate && q.bist_sel == 4'h8 |-> pin_pick == 8'hff)
        else $error("select eight did not pick all channels");

    chk_sel_none:
    assert property (q.bist_sel > 4'h8 |-> pin_pick == 8'h00)
        else $error("reserved select started a test");

    chk_act_low:
    assert property (tick && !q.selftest_activate && !rb_run |=> in_prbs == 8'h00)
        else $error("pattern sent with self-test inactive");

    chk_sync_hold:
    assert property (tick && s_sync[2] && q.sync_cnt[2] == 3'h3 && s_master && s_sleep[2]
                     && !ext_on && !rb_run && !pin_pick[2]
                     |=> q.mode[2] == sbo_pkg::SBO_MODE_SYNC
                         && serial_out_pairs_o[2] == 12'h03f)
        else $error("sync pattern not sent after four frames");

    chk_frame_bits:
    assert property (tick && q.mode[2] == sbo_pkg::SBO_MODE_DATA
                     ##1 q.mode[2] == sbo_pkg::SBO_MODE_DATA
                     |-> serial_out_pairs_o[2][0] && !serial_out_pairs_o[2][11]
                         && serial_out_pairs_o[2][10:1] == $past(s_word[2]))
        else $error("data frame framing or capture wrong");

    chk_sleep_idle:
    assert property (tick && !(s_master && s_sleep[3]) |=> serial_drive_n_o[3]
                     && q.mode[3] == sbo_pkg::SBO_MODE_SLEEP)
        else $error("sleeping channel not idle and tri-stated");

    chk_runbist_end:
    assert property (tick && rb_run && q.bist_frames == RB_LAST |=> q.bist_done ##1 !rb_run)
        else $error("run test did not finish at its frame count");

    chk_wb_ack:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after strobe");

endmodule // sbo_output_ctrl

`default_nettype wire

// ==== sbo_consts.svh ====
// Purpose: Shared constants for the serializer self-test and output control block
// Assumes: Included by bare name from every design file that needs it
// Notes:   Offsets are byte addresses on a 32-bit classic Wishbone slave
//
// How it works
// - Driver enable low tri-states all outputs
// - Enable high again resumes the prior state
// - Each channel can send internal PRBS pattern
// - Select 0 to 7 picks one channel
// - Select 8 tests every channel together
// - Select 9 to F means no test
// - Activate low means no test anywhere
// - Select inputs default high, giving no test
// - EXTEST drives serial outputs at set levels
// - RUNBIST runs pattern for fixed system clocks; the code counts RUNBIST_FRAMES frame ticks instead
// - Receiver reports pass and completion bits; the rx model has only pass_o, completion is bist_done in the status register
// - Ordering holds for scan or pin start
// - Word and clock bits form one stream
// - All words captured on transmit clock rise
// - Frame is start high, ten data, stop low
// - Sync high four clocks sends sync pattern
// - Data only when enabled, awake, no sync
// - Channel sleep idles and tri-states that channel
`ifndef SBO_CONSTS_SVH
`define SBO_CONSTS_SVH

// -----------------------------------------------------------------
// Register map
// -----------------------------------------------------------------
`define SBO_ADR_CTRL      8'h00
`define SBO_ADR_EXTEST    8'h04
`define SBO_ADR_STATUS    8'h08
`define SBO_ADR_FRAMES    8'h0c
`define SBO_CTRL_RTI_BIT  2
`define SBO_INSTR_NORMAL  2'h0
`define SBO_INSTR_EXTEST  2'h1
`define SBO_INSTR_RUNBIST 2'h2

// -----------------------------------------------------------------
// Framing and selection
// -----------------------------------------------------------------
`define SBO_START_BIT     1'b1
`define SBO_STOP_BIT      1'b0
`define SBO_SYNC_FRAME    12'h03f
`define SBO_SEL_ALL       4'h8
`define SBO_SEL_PULLUP    4'hf
`define SBO_SYNC_HOLD     3'h4
`define SBO_PRBS_SEED     15'h7fff

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SBO_RUNBIST_TIME_US 33000
`define SBO_SYS_CLK_MHZ     66

`endif

// ==== sbo_pkg.sv ====
// Purpose: Types shared by the serializer self-test and output control block
// Assumes: Constants live in sbo_consts.svh
// Notes:   The output control, synchronizer and PRBS modules each keep all of their state in one packed struct
`default_nettype none

package sbo_pkg;

    // Per-channel transmit source
    typedef enum logic [2:0] {
        SBO_MODE_SLEEP,
        SBO_MODE_TEST_LVL,
        SBO_MODE_PRBS,
        SBO_MODE_SYNC,
        SBO_MODE_DATA
    } sbo_mode_e;

    typedef struct packed {
        logic [14:0] lfsr;
        logic [9:0]  word;
    } sbo_prbs_s;

    typedef struct packed {
        logic                  transmit_ref_clock_prev;
        logic                  selftest_activate;
        logic [3:0]            bist_sel;
        logic [1:0]            instr;
        logic                  rti;
        logic [7:0]            extest;
        logic [21:0]           bist_frames;
        logic                  bist_done;
        logic [7:0][2:0]       sync_cnt;
        logic [7:0]            sync_mode;
        sbo_mode_e [7:0]       mode;
        logic [7:0][11:0]      frame;
        logic [7:0]            drive_n;
        logic                  frame_stb;
        logic                  ack;
        logic [31:0]           rdat;
    } sbo_state_s;

endpackage

`default_nettype wire

// ==== sbo_pin_sync.sv ====
// Purpose: Two-flop synchronizer for a vector of pins
// Assumes: Each bit is an independent level; words must be stable for a while
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none

module sbo_pin_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } sbo_sync_s;

    sbo_sync_s q;
    sbo_sync_s n;

    // -----------------------------------------------------------------
    // Two stages
    // -----------------------------------------------------------------
    always_comb begin
        n.meta = d_i;
        n.hold = q.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{meta: RST_VAL, hold: RST_VAL};
        end else begin
            q <= n;
        end
    end

    assign q_o = q.hold;

endmodule // sbo_pin_sync

`default_nettype wire

// ==== sbo_prbs_gen.sv ====
// Purpose: PRBS-15 source giving ten fresh bits per frame
// Assumes: adv_i is a one-cycle pulse per transmit frame
// Notes:   One generator feeds all channels; the checker only needs the sequence
`timescale 1ns/1ps
`default_nettype none
`include "sbo_consts.svh"

module sbo_prbs_gen (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       adv_i,
    output logic      [9:0] word_o
);
    sbo_pkg::sbo_prbs_s q;
    sbo_pkg::sbo_prbs_s n;

    // Advance the x^15 + x^14 + 1 register by ten bits
    function automatic sbo_pkg::sbo_prbs_s step10(input logic [14:0] l_in);
        sbo_pkg::sbo_prbs_s r;
        logic               fb;
        r.lfsr = l_in;
        r.word = 10'h000;
        for (int i = 0; i < 10; i++) begin
            fb        = r.lfsr[14] ^ r.lfsr[13];
            r.lfsr    = {r.lfsr[13:0], fb};
            r.word[i] = fb;
        end
        return r;
    endfunction

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        n = q;
        if (adv_i) begin
            n = step10(q.lfsr);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{lfsr: `SBO_PRBS_SEED, word: 10'h000};
        end else begin
            q <= n;
        end
    end

    assign word_o = q.word;

endmodule // sbo_prbs_gen

`default_nettype wire

// ==== sbo_rx_model.sv ====
// Purpose: Far-side receiver model that frames and checks incoming words
// Assumes: A fresh frame per channel is valid in the cycle of frame_strobe_i
// Notes:   A released pair carries no last value, so the word is inverted
`timescale 1ns/1ps
`default_nettype none

module sbo_rx_model (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             chk_en_i,
    input  wire logic             frame_strobe_i,
    input  wire logic [7:0][11:0] frame_i,
    input  wire logic [7:0]       drive_n_i,
    output logic      [7:0][9:0]  word_o,
    output logic      [15:0]      err_cnt_o,
    output logic                  pass_o
);
    int bad;

    // Count driven frames whose clock bits are wrong; sleep frames are silent
    always_comb begin
        bad = 0;
        for (int c = 0; c < 8; c++) begin
            if (!drive_n_i[c] && frame_i[c] != 12'h0 && {frame_i[c][11], frame_i[c][0]} != 2'b01)
                bad = bad + 1;
        end
    end

    // Capture payload once per frame; EXTEST levels are excused by chk_en_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_cnt_o <= 16'h0;
            word_o <= '0;
        end else if (frame_strobe_i) begin
            if (chk_en_i)
                err_cnt_o <= err_cnt_o + 16'(bad);
            for (int c = 0; c < 8; c++) begin
                word_o[c] <= drive_n_i[c] ? ~word_o[c] : frame_i[c][10:1];
            end
        end
    end

    assign pass_o = (err_cnt_o == 16'h0);
endmodule // sbo_rx_model

`default_nettype wire

// ==== tb_sbo_output_ctrl.sv ====
// Purpose: Self-checking bench for the output control and self-test block
// Assumes: Transmit clock is 10 system clocks; pins change after clk_i rises
// Notes:   RUNBIST length is shortened to RB frames
`timescale 1ns/1ps
`default_nettype none

module tb_sbo_output_ctrl;
    localparam int RB = 20;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic [7:0]       adr = 8'h0;
    logic [3:0]       sel = 4'h0;
    logic [31:0]      wdat = 32'h0;
    logic [31:0]      rdat;
    logic             ack;
    logic             transmit_ref_clock = 1'b0;
    int               tcnt = 0;
    logic             driver_output_enable = 1'b1;
    logic             msl = 1'b1;
    logic [7:0]       csl = 8'hff;
    logic [7:0]       syn = 8'h0;
    logic             act = 1'b0;
    logic [3:0]       bsel = 4'hf;
    logic [7:0][9:0]  pw;
    logic [7:0][11:0] so;
    logic [7:0]       dn;
    logic             fs;
    logic             rx_en = 1'b1;
    logic [7:0][9:0]  rx_word;
    logic [15:0]      rx_err;
    logic             rx_pass;
    logic [31:0]      q;
    int               n_mismatch = 0;
    int               compares = 0;

    function automatic logic [9:0] dw(input int n);
        return 10'h155 ^ (10'(n) << 4); // D0 high, D9 low
    endfunction

    function automatic logic [11:0] fr(input int n);
        return {1'b0, dw(n), 1'b1};
    endfunction

    initial begin
        for (int c = 0; c < 8; c++) pw[c] = dw(c);
    end

    sbo_output_ctrl #(.RUNBIST_FRAMES(RB)) i_sbo_output_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .transmit_ref_clock_i(transmit_ref_clock), .driver_output_enable_i(driver_output_enable),
        .master_sleep_n_i(msl), .channel_sleep_n_i(csl), .sync_request_i(syn),
        .selftest_activate_i(act), .selftest_channel_select_i(bsel),
        .parallel_word_in_i(pw), .serial_out_pairs_o(so), .serial_drive_n_o(dn),
        .frame_strobe_o(fs));

    sbo_rx_model i_sbo_rx_model (
        .clk_i(clk_i), .rst_i(rst_i), .chk_en_i(rx_en), .frame_strobe_i(fs),
        .frame_i(so), .drive_n_i(dn), .word_o(rx_word), .err_cnt_o(rx_err),
        .pass_o(rx_pass));

    // -----------------------------------------------------------------
    // Clocks
    // -----------------------------------------------------------------
    always #4 clk_i = ~clk_i;

    // Link clock of 80 ns made on clk_i edges, so it never races a sample
    always @(posedge clk_i) begin
        tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
        if (tcnt == 4) transmit_ref_clock <= ~transmit_ref_clock;
    end

    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic tally_and_finish;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_fr(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (t >= 20) n_mismatch++;
    endtask

    // Wait for k frame strobes; frames then stand until the next tick
    task automatic ticks(input int k);
        int t;
        repeat (k) begin
            t = 0;
            do begin
                @(posedge clk_i);
                t++;
            end while (fs !== 1'b1 && t < 100);
            if (t >= 100) n_mismatch++;
        end
    endtask

    // Set self-test pins, let the sampled copy take effect, check every channel
    task automatic bist(input logic a, input logic [3:0] s, input logic [7:0] m);
        act <= a;
        bsel <= s;
        ticks(3);
        for (int c = 0; c < 8; c++) begin
            if (m[c]) begin
                chk_reg("prbs_on", 32'h1, {31'h0, so[c][10:1] !== dw(c)});
                if (m == 8'hff) chk_fr("prbs_same", so[0], so[c]);
            end else begin
                chk_fr("data", fr(c), so[c]);
            end
        end
    endtask

    // -----------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        ticks(3);
        chk_reg("drive_n", 32'h0, 32'(dn));
        for (int c = 0; c < 8; c++) chk_fr("frame", fr(c), so[c]);
        for (int s = 0; s < 16; s++)
            bist(1'b1, 4'(s), s < 8 ? 8'(1 << s) : (s == 8 ? 8'hff : 8'h00));
        bist(1'b0, 4'h3, 8'h00);
        bist(1'b0, 4'hf, 8'h00);
        syn[2] <= 1'b1;
        ticks(3);
        chk_fr("sync_early", fr(2), so[2]);
        ticks(2);
        chk_fr("sync", 12'h03f, so[2]);
        chk_fr("sync_other", fr(3), so[3]);
        syn[2] <= 1'b0;
        ticks(3);
        chk_fr("sync_off", fr(2), so[2]);
        driver_output_enable <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk_reg("den_off", 32'hff, 32'(dn));
        driver_output_enable <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk_reg("den_on", 32'h0, 32'(dn));
        ticks(1);
        for (int c = 0; c < 8; c++) chk_fr("resume", fr(c), so[c]);
        csl[5] <= 1'b0;
        ticks(2);
        chk_reg("ch_sleep", 32'h20, 32'(dn));
        chk_fr("ch_sleep_frame", 12'h0, so[5]);
        chk_fr("ch_neighbour", fr(4), so[4]);
        csl[5] <= 1'b1;
        ticks(2);
        chk_fr("ch_wake", fr(5), so[5]);
        msl <= 1'b0;
        ticks(2);
        chk_reg("dev_sleep", 32'hff, 32'(dn));
        msl <= 1'b1;
        ticks(2);
        chk_reg("dev_wake", 32'h0, 32'(dn));
        wb(1'b0, 8'h00, 32'h0, 4'hf, q);
        chk_reg("ctrl_reset", 32'h0, q);
        wb(1'b1, 8'h00, 32'h1, 4'he, q);
        wb(1'b0, 8'h00, 32'h0, 4'hf, q);
        chk_reg("ctrl_sel", 32'h0, q);
        wb(1'b1, 8'h10, 32'h5, 4'hf, q);
        wb(1'b0, 8'h10, 32'h0, 4'hf, q);
        chk_reg("unmapped", 32'h0, q);
        wb(1'b1, 8'h04, 32'hffffffa5, 4'hf, q);
        wb(1'b0, 8'h04, 32'h0, 4'hf, q);
        chk_reg("extest_reg", 32'ha5, q);
        rx_en <= 1'b0;
        wb(1'b1, 8'h00, 32'h1, 4'hf, q);
        ticks(2);
        for (int c = 0; c < 8; c++)
            chk_fr("extest", ((8'ha5 >> c) & 8'h01) != 8'h00 ? 12'hfff : 12'h0, so[c]);
        // Far receiver is modelled as already idle, so the run starts at once
        wb(1'b1, 8'h00, 32'h6, 4'hf, q);
        ticks(2);
        rx_en <= 1'b1;
        ticks(1);
        chk_reg("runbist_prbs", 32'h1, {31'h0, so[0][10:1] !== dw(0)});
        ticks(RB + 2);
        wb(1'b0, 8'h08, 32'h0, 4'hf, q);
        chk_reg("runbist_done", 32'h1, q & 32'h1);
        wb(1'b0, 8'h0c, 32'h0, 4'hf, q);
        chk_reg("runbist_frames", 32'(RB), q);
        ticks(1);
        chk_fr("runbist_stop", fr(0), so[0]);
        wb(1'b1, 8'h00, 32'h0, 4'hf, q);
        wb(1'b0, 8'h08, 32'h0, 4'hf, q);
        chk_reg("done_clear", 32'h0, q & 32'h1);
        ticks(1);
        chk_reg("rx_word", 32'(dw(1)), 32'(rx_word[1]));
        chk_reg("rx_errors", 32'h1, 32'(rx_pass));
        tally_and_finish();
    end

    // Whole run is near 1050 cycles; a hang is cut off well beyond it
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end
endmodule // tb_sbo_output_ctrl

`default_nettype wire
